// >>> hdl/lmt_translator.sv
// What this block does
// R1: One-to-one, confirmed, sequenced establish binds with acked sequenced variant.
// R2: One-to-one, confirmed, unsequenced establish binds with acked unsequenced variant.
// R3: One-to-one, unconfirmed, unsequenced establish binds with unacked unsequenced variant.
// R4: One-to-many, unconfirmed, unsequenced establish binds with multipoint unsequenced variant.
// R5: One-to-many, unconfirmed, sequenced establish binds with multipoint sequenced variant.
// R6: Link answers bind at once; confirm establish upstream with returned access point.
// R7: Abort request issues link detach and abort indication, no data moved.
// R8: Transfer request selects access point, then sends frame to called address.
// R9: Frame indication with unknown called address is dropped silently.
// R10: Matching frame indication yields PDU indication with calling address and data.
// R11: Failed frame confirm sends error report, then PDU confirm with status.
// R12: Successful frame confirm sends only PDU confirm with success status.
// R13: Selected access point attributes are ready in the same cycle as the frame request goes.
// R14: Endpoint lookup true only for a bound endpoint; exposes its attributes.
// R15: Single active state, always returns there; pdu_req_ready drops while the transfer FIFO is full.
// R16: Establish with undefined combination is ignored; no bind issued.
`timescale 1ns/1ns
`default_nettype none
module lmt_translator
    import lmt_pkg::*;
#(
    parameter int ADDR_W = LMT_ADDR_W,
    parameter int SAP_W = LMT_SAP_W,
    parameter int DATA_W = LMT_DATA_W,
    parameter int EP_NUM = LMT_EP_NUM,
    parameter int DEPTH = LMT_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    // Upper relationship protocol machine
    input wire logic est_req,
    input wire logic est_card,
    input wire logic est_remote_confirm,
    input wire logic est_seq_control,
    output logic est_cnf,
    output logic [SAP_W-1:0] est_cnf_sap,
    input wire logic abort_req,
    output logic abort_ind,
    input wire logic pdu_req_valid,
    output logic pdu_req_ready,
    input wire logic [SAP_W-1:0] pdu_req_sap,
    input wire logic [ADDR_W-1:0] pdu_req_called,
    input wire logic [DATA_W-1:0] pdu_req_data,
    output logic pdu_ind,
    output logic [ADDR_W-1:0] pdu_ind_calling,
    output logic [DATA_W-1:0] pdu_ind_data,
    output logic [$clog2(EP_NUM)-1:0] pdu_ind_endpoint,
    output logic pdu_cnf,
    output logic [7:0] pdu_cnf_status,
    output logic error_report_upstream,
    output logic [1:0] error_originator,
    output logic [7:0] error_reason,
    // Endpoint table, provisioned locally
    input wire logic [EP_NUM-1:0] ep_bound,
    input wire logic [EP_NUM*ADDR_W-1:0] ep_addr,
    // Link layer service
    output logic link_attach_request,
    output logic [2:0] link_service_variant,
    input wire logic link_attach_sap_valid,
    input wire logic [SAP_W-1:0] link_attach_sap,
    output logic link_detach_request,
    output logic link_frame_request,
    input wire logic link_frame_ready,
    output logic [SAP_W-1:0] link_frame_sap,
    output logic [ADDR_W-1:0] link_frame_called,
    output logic [DATA_W-1:0] link_frame_data,
    input wire logic link_frame_indication,
    input wire logic [ADDR_W-1:0] link_ind_called,
    input wire logic [ADDR_W-1:0] link_ind_calling,
    input wire logic [DATA_W-1:0] link_ind_data,
    input wire logic link_frame_confirm,
    input wire logic [7:0] link_cnf_status
);
    localparam int EPW = $clog2(EP_NUM);
    localparam int FW = SAP_W + ADDR_W + DATA_W;

    lmt_state_t state_q;

    // Maps establish parameters to a link variant
    function automatic logic [2:0] variant_of(input logic card, input logic rc,
                                              input logic sc);
        logic [2:0] v;
        v = LMT_VAR_NONE;
        if (card == LMT_CARD_ONE_TO_ONE) begin
            // R1: acked sequenced
            if (rc && sc) begin
                v = LMT_VAR_ACKED_SEQUENCED;
            end
            // R2: acked unsequenced
            if (rc && !sc) begin
                v = LMT_VAR_ACKED_UNSEQUENCED;
            end
            // R3: unacked unsequenced
            if (!rc && !sc) begin
                v = LMT_VAR_UNACKED_UNSEQUENCED;
            end
        end else begin
            // R4: multipoint unsequenced
            if (!rc && !sc) begin
                v = LMT_VAR_MULTIPOINT_UNSEQUENCED;
            end
            // R5: multipoint sequenced
            if (!rc && sc) begin
                v = LMT_VAR_MULTIPOINT_SEQUENCED;
            end
        end
        return v;
    endfunction : variant_of

    // R14: endpoint lookup
    logic ep_hit;
    logic [EPW-1:0] ep_idx;
    always_comb begin
        ep_hit = 1'b0;
        ep_idx = '0;
        for (int i = EP_NUM - 1; i >= 0; i--) begin
            if (ep_bound[i] && ep_addr[i*ADDR_W +: ADDR_W] == link_ind_called) begin
                ep_hit = 1'b1;
                ep_idx = EPW'(i);
            end
        end
    end

    // R15: single active state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= LMT_ACTIVE;
        end else begin
            case (state_q)
                LMT_ACTIVE: state_q <= LMT_ACTIVE;
                default: state_q <= LMT_ACTIVE;
            endcase
        end
    end

    // Establish path
    logic [2:0] var_d;
    logic bind_pend_q;
    assign var_d = variant_of(est_card, est_remote_confirm, est_seq_control);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_attach_request <= 1'b0;
            link_service_variant <= LMT_VAR_NONE;
            bind_pend_q <= 1'b0;
            est_cnf <= 1'b0;
            est_cnf_sap <= '0;
        end else begin
            // R16: undefined combination ignored
            link_attach_request <= est_req && (var_d != LMT_VAR_NONE);
            if (est_req && var_d != LMT_VAR_NONE) begin
                link_service_variant <= var_d;
            end
            bind_pend_q <= est_req && (var_d != LMT_VAR_NONE);
            // R6: confirm on immediate answer
            est_cnf <= bind_pend_q && link_attach_sap_valid;
            if (bind_pend_q && link_attach_sap_valid) begin
                est_cnf_sap <= link_attach_sap;
            end
        end
    end

    // R7: abort maps to detach
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_detach_request <= 1'b0;
            abort_ind <= 1'b0;
        end else begin
            link_detach_request <= abort_req;
            abort_ind <= abort_req;
        end
    end

    // Transfer path through FIFO; back-pressure reaches pdu_req_ready
    logic f_valid;
    logic f_ready;
    logic [FW-1:0] f_data;
    lmt_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(pdu_req_valid),
        .in_ready(pdu_req_ready),
        .in_data({pdu_req_sap, pdu_req_called, pdu_req_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    // Output stage holds a frame until the link takes it
    assign f_ready = !link_frame_request || link_frame_ready;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_frame_request <= 1'b0;
            link_frame_sap <= '0;
            link_frame_called <= '0;
            link_frame_data <= '0;
        end else if (f_ready) begin
            link_frame_request <= f_valid;
            if (f_valid) begin
                // R13: sap latched with frame
                // R8: select sap, then send
                link_frame_sap <= f_data[FW-1 -: SAP_W];
                link_frame_called <= f_data[DATA_W +: ADDR_W];
                link_frame_data <= f_data[DATA_W-1:0];
            end
        end
    end

    // Receive path
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pdu_ind <= 1'b0;
            pdu_ind_calling <= '0;
            pdu_ind_data <= '0;
            pdu_ind_endpoint <= '0;
        end else begin
            // R9: drop unknown address
            pdu_ind <= link_frame_indication && ep_hit;
            if (link_frame_indication && ep_hit) begin
                // R10: pass calling address and data
                pdu_ind_calling <= link_ind_calling;
                pdu_ind_data <= link_ind_data;
                pdu_ind_endpoint <= ep_idx;
            end
        end
    end

    // Confirm path; error report leads PDU confirm by one cycle
    logic cnf_pend_q;
    logic [7:0] cnf_stat_q;
    logic is_fail;
    assign is_fail = link_cnf_status != LMT_STATUS_SUCCESS;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            error_report_upstream <= 1'b0;
            error_originator <= '0;
            error_reason <= '0;
            cnf_pend_q <= 1'b0;
            cnf_stat_q <= '0;
            pdu_cnf <= 1'b0;
            pdu_cnf_status <= '0;
        end else begin
            // R11: error report first
            error_report_upstream <= link_frame_confirm && is_fail;
            if (link_frame_confirm && is_fail) begin
                error_originator <= LMT_ORIG_LOCAL_LINK;
                error_reason <= link_cnf_status;
            end
            cnf_pend_q <= link_frame_confirm;
            if (link_frame_confirm) begin
                cnf_stat_q <= link_cnf_status;
            end
            // R12: PDU confirm carries status
            pdu_cnf <= cnf_pend_q;
            if (cnf_pend_q) begin
                pdu_cnf_status <= cnf_stat_q;
            end
        end
    end
endmodule : lmt_translator
`default_nettype wire

// >>> hdl/lmt_pkg.sv
package lmt_pkg;
    // Link service variant codes; values are local encodings
    localparam logic [2:0] LMT_VAR_ACKED_SEQUENCED = 3'h1;
    localparam logic [2:0] LMT_VAR_ACKED_UNSEQUENCED = 3'h2;
    localparam logic [2:0] LMT_VAR_UNACKED_UNSEQUENCED = 3'h3;
    localparam logic [2:0] LMT_VAR_MULTIPOINT_UNSEQUENCED = 3'h4;
    localparam logic [2:0] LMT_VAR_MULTIPOINT_SEQUENCED = 3'h5;
    localparam logic [2:0] LMT_VAR_NONE = 3'h0;
    // Cardinality encoding
    localparam logic LMT_CARD_ONE_TO_ONE = 1'b0;
    localparam logic LMT_CARD_ONE_TO_MANY = 1'b1;
    // Link status value meaning success
    localparam logic [7:0] LMT_STATUS_SUCCESS = 8'h00;
    // Originator code for the local link service
    localparam logic [1:0] LMT_ORIG_LOCAL_LINK = 2'h1;
    localparam int LMT_FIFO_DEPTH = 16;
    localparam int LMT_ADDR_W = 16;
    localparam int LMT_SAP_W = 8;
    localparam int LMT_DATA_W = 32;
    localparam int LMT_EP_NUM = 4;
    typedef enum logic [0:0] {
        LMT_ACTIVE = 1'b0
    } lmt_state_t;
endpackage : lmt_pkg

// >>> hdl/lmt_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module lmt_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;
    assign out_valid = (cnt_q != '0);
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            // Registered so upstream ready comes straight from a flop
            in_ready <= (cnt_d != DEPTH[AW:0]);
        end
    end
endmodule : lmt_fifo
`default_nettype wire

// >>> tb/lmt_translator_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module lmt_asserts
    import lmt_pkg::*;
#(
    parameter int SAP_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic est_req,
    input wire logic est_card,
    input wire logic est_remote_confirm,
    input wire logic est_seq_control,
    input wire logic est_cnf,
    input wire logic [SAP_W-1:0] est_cnf_sap,
    input wire logic abort_req,
    input wire logic abort_ind,
    input wire logic link_detach_request,
    input wire logic link_attach_request,
    input wire logic [2:0] link_service_variant,
    input wire logic link_attach_sap_valid,
    input wire logic [SAP_W-1:0] link_attach_sap,
    input wire logic link_frame_confirm,
    input wire logic [7:0] link_cnf_status,
    input wire logic error_report_upstream,
    input wire logic [1:0] error_originator,
    input wire logic [7:0] error_reason,
    input wire logic pdu_cnf,
    input wire logic [7:0] pdu_cnf_status
);
    // Index is {cardinality, remote confirm, sequence control}
    localparam logic [2:0] VMAP [8] = '{LMT_VAR_UNACKED_UNSEQUENCED, LMT_VAR_NONE,
        LMT_VAR_ACKED_UNSEQUENCED, LMT_VAR_ACKED_SEQUENCED, LMT_VAR_MULTIPOINT_UNSEQUENCED,
        LMT_VAR_MULTIPOINT_SEQUENCED, LMT_VAR_NONE, LMT_VAR_NONE};
    wire logic [2:0] var_exp = VMAP[{est_card, est_remote_confirm, est_seq_control}];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    bind_variant_a: assert property (est_req && var_exp != LMT_VAR_NONE |=>
        link_attach_request && link_service_variant == $past(var_exp))
        else $error("attach variant wrong");
    undef_combo_a: assert property (est_req && var_exp == LMT_VAR_NONE |=>
        !link_attach_request) else $error("attach on undefined combination");
    est_confirm_a: assert property (link_attach_request && link_attach_sap_valid |=>
        est_cnf && est_cnf_sap == $past(link_attach_sap)) else $error("establish confirm wrong");
    abort_pair_a: assert property (abort_req |=> link_detach_request && abort_ind)
        else $error("abort outputs missing");
    detach_cause_a: assert property (link_detach_request |-> $past(abort_req))
        else $error("detach without abort");
    fail_report_a: assert property (
        link_frame_confirm && link_cnf_status != LMT_STATUS_SUCCESS |=> (error_report_upstream
        && error_originator == LMT_ORIG_LOCAL_LINK && error_reason == $past(link_cnf_status))
        ##1 (pdu_cnf && pdu_cnf_status == $past(link_cnf_status, 2))) else $error("bad fail");
    success_quiet_a: assert property (
        link_frame_confirm && link_cnf_status == LMT_STATUS_SUCCESS |=> !error_report_upstream
        ##1 (pdu_cnf && pdu_cnf_status == LMT_STATUS_SUCCESS)) else $error("bad success");
    cnf_cause_a: assert property (pdu_cnf |-> $past(link_frame_confirm, 2))
        else $error("confirm without cause");
endmodule : lmt_asserts
bind lmt_translator lmt_asserts #(.SAP_W(SAP_W)) u_lmt_asserts (.*);
`default_nettype wire

// >>> tb/lmt_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module lmt_link_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic link_attach_request,
    output logic link_attach_sap_valid,
    output logic [7:0] link_attach_sap,
    input wire logic link_frame_request,
    output logic link_frame_ready
);
    logic [7:0] sap_q;
    assign link_attach_sap_valid = link_attach_request;
    // Stale value inverted so nobody reads it by luck
    assign link_attach_sap = link_attach_request ? sap_q : ~sap_q;
    assign link_frame_ready = link_frame_request && !stall;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sap_q <= 8'h40;
        end else if (link_attach_request) begin
            sap_q <= sap_q + 8'h01;
        end
    end
endmodule : lmt_link_model
`default_nettype wire

// >>> tb/lmt_translator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lmt_translator_tb
    import lmt_pkg::*;
;
    logic ref_clk = 0, rst_b = 0, stall = 0, est_req = 0, est_card = 0, abort_req = 0;
    logic est_remote_confirm = 0, est_seq_control = 0, pdu_req_valid = 0;
    logic link_frame_indication = 0, link_frame_confirm = 0, est_cnf, abort_ind, pdu_req_ready;
    logic pdu_ind, pdu_cnf, error_report_upstream, link_attach_request, link_attach_sap_valid;
    logic link_detach_request, link_frame_request, link_frame_ready;
    logic [7:0] pdu_req_sap = 0, link_cnf_status = 0, est_cnf_sap, link_attach_sap;
    logic [7:0] link_frame_sap, pdu_cnf_status, error_reason, exp_sap = 8'h40;
    logic [15:0] pdu_req_called = 0, link_ind_called = 0, link_ind_calling = 0;
    logic [15:0] pdu_ind_calling, link_frame_called;
    logic [31:0] pdu_req_data = 0, link_ind_data = 0, pdu_ind_data, link_frame_data;
    logic [3:0] ep_bound = 4'h6;
    logic [63:0] ep_addr = 64'h0444_0333_0222_0111;
    logic [2:0] link_service_variant;
    logic [1:0] pdu_ind_endpoint, error_originator;
    logic [63:0] q[8][$];
    int err_total = 0, checks_done = 0, cyc = 0, n = 0;
    localparam logic [2:0] VMAP [8] = '{LMT_VAR_UNACKED_UNSEQUENCED, LMT_VAR_NONE,
        LMT_VAR_ACKED_UNSEQUENCED, LMT_VAR_ACKED_SEQUENCED, LMT_VAR_MULTIPOINT_UNSEQUENCED,
        LMT_VAR_MULTIPOINT_SEQUENCED, LMT_VAR_NONE, LMT_VAR_NONE};
    lmt_translator #(.DEPTH(16)) uut (.*);
    lmt_link_model link_far (.*);
    always #4 ref_clk = ~ref_clk;
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Empty queue yields unknown, so a stray output fails
    function automatic logic [63:0] pop(input int k);
        return q[k].size() > 0 ? q[k].pop_front() : 'x;
    endfunction : pop
    task automatic stop_test;
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    always @(posedge ref_clk) begin
        #2;
        cyc++;
        if (link_attach_request) check(link_service_variant, pop(1));
        if (est_cnf) check(est_cnf_sap, pop(2));
        if (abort_ind || link_detach_request) check({abort_ind, link_detach_request}, pop(3));
        if (link_frame_request && link_frame_ready)
            check({link_frame_sap, link_frame_called, link_frame_data}, pop(4));
        if (pdu_ind) check({pdu_ind_endpoint, pdu_ind_calling, pdu_ind_data}, pop(5));
        if (error_report_upstream) check({error_originator, error_reason}, pop(6));
        if (pdu_cnf) check(pdu_cnf_status, pop(7));
        // Timeout last, so nothing runs after the end of the run
        if (cyc == 2000) begin
            err_total++;
            stop_test;
        end
    end
    initial begin
        void'($urandom(32'hf984));
        repeat (4) @(posedge ref_clk);
        #1;
        rst_b = 1;
        est_req = 1;
        for (int i = 0; i < 8; i++) begin
            {est_card, est_remote_confirm, est_seq_control} = i[2:0];
            if (VMAP[i] != LMT_VAR_NONE) begin
                q[1].push_back(VMAP[i]);
                q[2].push_back(exp_sap++);
            end
            tick;
        end
        est_req = 0;
        abort_req = 1;
        q[3] = '{64'h3, 64'h3};
        tick;
        tick;
        abort_req = 0;
        stall = 1;
        pdu_req_valid = 1;
        while (pdu_req_ready === 1'b1 && n < 40) begin
            {pdu_req_sap, pdu_req_called, pdu_req_data} = {24'($urandom), $urandom};
            q[4].push_back({pdu_req_sap, pdu_req_called, pdu_req_data});
            n++;
            tick;
        end
        check(n >= 16, 1);
        tick;
        check(pdu_req_ready, 0);
        pdu_req_valid = 0;
        // Drain with the link stalling at random
        while (q[4].size() > 0) begin
            stall = 1'($urandom);
            tick;
        end
        stall = 0;
        link_frame_indication = 1;
        for (int i = 0; i < 5; i++) begin
            link_ind_called = 16'(16'h0111 * (i + 1));
            {link_ind_calling, link_ind_data} = {16'($urandom), $urandom};
            if (ep_bound[i % 4]) q[5].push_back({2'(i), link_ind_calling, link_ind_data});
            tick;
        end
        link_frame_indication = 0;
        link_frame_confirm = 1;
        for (int i = 0; i < 4; i++) begin
            link_cnf_status = i[0] ? 8'($urandom | 1) : LMT_STATUS_SUCCESS;
            if (i[0]) q[6].push_back({LMT_ORIG_LOCAL_LINK, link_cnf_status});
            q[7].push_back(link_cnf_status);
            tick;
        end
        link_frame_confirm = 0;
        repeat (4) tick;
        // reset mid-run, then establish at the first edge
        rst_b = 0;
        tick;
        check({est_cnf, abort_ind, pdu_ind, pdu_cnf, error_report_upstream}, 0);
        check({link_attach_request, link_detach_request, link_frame_request}, 0);
        check(pdu_req_ready, 1);
        check({est_cnf_sap, link_service_variant, error_originator, error_reason}, 0);
        check({pdu_cnf_status, link_frame_sap, link_frame_called, pdu_ind_calling}, 0);
        check({link_frame_data, pdu_ind_data}, 0);
        check(pdu_ind_endpoint, 0);
        rst_b = 1;
        est_req = 1;
        {est_card, est_remote_confirm, est_seq_control} = 3'h5;
        q[1].push_back(VMAP[5]);
        q[2].push_back(8'h40);
        tick;
        est_req = 0;
        repeat (4) tick;
        for (int k = 1; k < 8; k++) check(q[k].size(), 0);
        stop_test;
    end
endmodule : lmt_translator_tb
`default_nettype wire
